/* File: hdl/scw_top.sv */
// Write-only two-wire control port of a dual-PLL clock synthesizer.
// Function
// - Seven-bit address plus direction bit; acknowledge when address matches and direction bit is low.
// - Data bytes are eight bits, MSB first, each acknowledged.
// - First byte bits below the top enable outputs fifteen to nine.
// - Second byte bits below the top enable outputs seven to one.
// - Third byte: divider code, spread enable, then bypass select in bit zero.
// - Fourth byte follows third, then stop; holds revision, low six reserved.
// - Bytes held in shadow, copied to active registers only at stop.
// - Enable change reaches the output within ten ns plus one period.
// - Address 1001100 with select low, 1001110 with select high.
// - Top bits: output sixteen, eight, zero, and output twelve frequency.
// - A write is the address then exactly four data bytes, then stop.
// - Reset restores defaults and floats outputs zero to eleven.
`timescale 1ns/1ps
module scw_top (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic ADDR_SEL_I,
  output logic [16:0] OUT_ON_O,
  output logic [4:0] FB_DIV_O,
  output logic SPREAD_ENABLE_O,
  output logic BYPASS_O,
  output logic Q12_FREQ_SEL_O,
  output logic REVISION_O,
  output logic [11:0] OUT_HIZ_O
);
  scw_stream_if #(.WIDTH(scw_pkg::ITEM_W)) push_if ();
  scw_stream_if #(.WIDTH(scw_pkg::ITEM_W)) pop_if ();

  scw_fifo #(.WIDTH(scw_pkg::ITEM_W), .DEPTH(scw_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .wr(push_if.snk),
    .rd(pop_if.src)
  );

  // Pins are asynchronous to the core clock, so each passes two flops.
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, sel_s1, sel_s2;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
    end else begin
      scl_s1 <= SCL_I;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      sel_s1 <= ADDR_SEL_I;
      sel_s2 <= sel_s1;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && !sda_s2 && sda_d;
  assign bus_stop = scl_s2 && scl_d && sda_s2 && !sda_d;

  scw_pkg::scw_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic oe_reg, oe_next, sel_reg, sel_next;
  logic push_v_reg, push_v_next;
  logic [scw_pkg::ITEM_W-1:0] push_d_reg, push_d_next;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    sel_next = sel_reg;
    push_v_next = 1'b0;
    push_d_next = push_d_reg;
    if (bus_start) begin
      state_next = scw_pkg::ST_ADDR;
      cnt_next = '0;
      oe_next = 1'b0;
      // A restart to another address must not let the next stop commit.
      sel_next = 1'b0;
    end else if (bus_stop) begin
      state_next = scw_pkg::ST_IDLE;
      oe_next = 1'b0;
      if (sel_reg) begin
        push_v_next = 1'b1;
        push_d_next = {scw_pkg::KIND_STOP, 8'h00};
        sel_next = 1'b0;
      end
    end else begin
      case (state_reg)
        scw_pkg::ST_ADDR, scw_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s2};
            cnt_next = cnt_reg + 1'b1;
          end else if (scl_fall && cnt_reg == scw_pkg::BITS_PER_BYTE) begin
            if (state_reg == scw_pkg::ST_ADDR) begin
              if (scw_pkg::scw_addr_hit(shift_reg, sel_s2)) begin
                oe_next = 1'b1;
                sel_next = 1'b1;
                state_next = scw_pkg::ST_ADDR_ACK;
                push_v_next = 1'b1;
                push_d_next = {scw_pkg::KIND_START, 8'h00};
              end else begin
                state_next = scw_pkg::ST_IGNORE;
              end
            end else if (push_if.ready) begin
              oe_next = 1'b1;
              state_next = scw_pkg::ST_DATA_ACK;
              push_v_next = 1'b1;
              push_d_next = {scw_pkg::KIND_DATA, shift_reg};
            end else begin
              // A full buffer refuses the byte by leaving it unacknowledged.
              state_next = scw_pkg::ST_IGNORE;
            end
          end
        end
        scw_pkg::ST_ADDR_ACK, scw_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            cnt_next = '0;
            state_next = scw_pkg::ST_DATA;
          end
        end
        scw_pkg::ST_IDLE, scw_pkg::ST_IGNORE: begin
          oe_next = 1'b0;
        end
        default: begin
          state_next = scw_pkg::ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= scw_pkg::ST_IDLE;
      shift_reg <= '0;
      cnt_reg <= '0;
      oe_reg <= 1'b0;
      sel_reg <= 1'b0;
      push_v_reg <= 1'b0;
      push_d_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      sel_reg <= sel_next;
      push_v_reg <= push_v_next;
      push_d_reg <= push_d_next;
    end
  end

  assign push_if.valid = push_v_reg;
  assign push_if.data = push_d_reg;

  // Drain side: collect bytes into the shadow, commit on a clean stop.
  logic [7:0] shadow_reg [scw_pkg::NUM_BYTES];
  logic [7:0] shadow_next [scw_pkg::NUM_BYTES];
  logic [7:0] act_reg [scw_pkg::NUM_BYTES];
  logic [7:0] act_next [scw_pkg::NUM_BYTES];
  logic [2:0] bcnt_reg, bcnt_next;
  logic commit_reg, commit_next, hiz_reg;
  logic [1:0] kind;

  // The commit cycle stalls the drain so the active copy settles first.
  assign pop_if.ready = !commit_reg;
  assign kind = pop_if.data[scw_pkg::ITEM_W-1:scw_pkg::BYTE_W];

  always_comb begin
    shadow_next = shadow_reg;
    act_next = act_reg;
    bcnt_next = bcnt_reg;
    commit_next = 1'b0;
    if (pop_if.valid && pop_if.ready) begin
      case (kind)
        scw_pkg::KIND_START: begin
          bcnt_next = '0;
        end
        scw_pkg::KIND_DATA: begin
          if (bcnt_reg < scw_pkg::BYTES_FULL) begin
            shadow_next[bcnt_reg[1:0]] = pop_if.data[7:0];
          end
          if (bcnt_reg != scw_pkg::BYTES_OVER) begin
            bcnt_next = bcnt_reg + 1'b1;
          end
        end
        scw_pkg::KIND_STOP: begin
          if (bcnt_reg == scw_pkg::BYTES_FULL) begin
            act_next = shadow_reg;
            act_next[3] = (shadow_reg[3] & scw_pkg::BYTE3_WRITE_MASK)
              | (scw_pkg::BYTE3_RESET & ~scw_pkg::BYTE3_WRITE_MASK);
            commit_next = 1'b1;
          end
          bcnt_next = '0;
        end
        default: begin
          bcnt_next = bcnt_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < scw_pkg::NUM_BYTES; i++) begin
        shadow_reg[i] <= '0;
      end
      act_reg[0] <= scw_pkg::BYTE0_RESET;
      act_reg[1] <= scw_pkg::BYTE1_RESET;
      act_reg[2] <= scw_pkg::BYTE2_RESET;
      act_reg[3] <= scw_pkg::BYTE3_RESET;
      bcnt_reg <= '0;
      commit_reg <= 1'b0;
      hiz_reg <= 1'b1;
    end else begin
      shadow_reg <= shadow_next;
      act_reg <= act_next;
      bcnt_reg <= bcnt_next;
      commit_reg <= commit_next;
      hiz_reg <= 1'b0;
    end
  end

  // Enables leave straight from the active flops, well inside the bound.
  assign OUT_ON_O = {act_reg[0], act_reg[1],
                     act_reg[2][scw_pkg::B2_OUT0_POS]};
  assign FB_DIV_O = act_reg[2][scw_pkg::FB_DIV_HI:scw_pkg::FB_DIV_LO];
  assign SPREAD_ENABLE_O = act_reg[2][scw_pkg::SPREAD_POS];
  assign BYPASS_O = act_reg[2][scw_pkg::BYPASS_POS];
  assign Q12_FREQ_SEL_O = act_reg[3][scw_pkg::FREQ_POS];
  assign REVISION_O = act_reg[3][scw_pkg::REV_POS];
  assign OUT_HIZ_O = {scw_pkg::HIZ_W{hiz_reg}};
  assign SDA_OE_O = oe_reg;
  assign SDA_O = 1'b0;
endmodule : scw_top

/* File: hdl/scw_pkg.sv */
// Constants and types shared by the control write port design.
package scw_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int KIND_W = 2;
  localparam int ITEM_W = KIND_W + BYTE_W;
  localparam int NUM_BYTES = 4;
  localparam logic [2:0] BYTES_FULL = 3'h4;
  localparam logic [2:0] BYTES_OVER = 3'h5;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_START = 2'h1;
  localparam logic [1:0] KIND_STOP = 2'h2;
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4C;
  localparam int ADDR_SEL_POS = 1;
  localparam int RW_POS = 0;
  localparam logic [7:0] BYTE0_RESET = 8'hF7;
  localparam logic [7:0] BYTE1_RESET = 8'hFF;
  localparam logic [7:0] BYTE2_RESET = 8'hA0;
  localparam logic [7:0] BYTE3_RESET = 8'h40;
  localparam logic [7:0] BYTE3_WRITE_MASK = 8'h80;
  localparam int B2_OUT0_POS = 7;
  localparam int FB_DIV_HI = 6;
  localparam int FB_DIV_LO = 2;
  localparam int SPREAD_POS = 1;
  localparam int BYPASS_POS = 0;
  localparam int FREQ_POS = 7;
  localparam int REV_POS = 6;
  localparam int HIZ_W = 12;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DATA_ACK = 6'h10,
    ST_IGNORE = 6'h20
  } scw_state_t;

  function automatic logic scw_addr_hit(input logic [7:0] frame,
                                        input logic sel);
    logic [6:0] want;
    want = SLAVE_ADDR_BASE;
    want[ADDR_SEL_POS] = sel;
    return (frame[7:1] == want) && !frame[RW_POS];
  endfunction : scw_addr_hit
endpackage : scw_pkg

/* File: hdl/scw_stream_if.sv */
// Valid and ready stream carrying bytes and frame markers between modules.
`timescale 1ns/1ps
interface scw_stream_if #(parameter int WIDTH = 10);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : scw_stream_if

/* File: hdl/scw_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module scw_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  scw_stream_if.snk wr,
  scw_stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  assign wr.ready = cnt_reg != DEPTH_CNT;
  assign rd.valid = cnt_reg != '0;
  assign rd.data = mem_reg[rp_reg];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd.valid && rd.ready;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (do_wr) begin
      wp_next = (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
    end
    if (do_rd) begin
      rp_next = (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only words below the count are ever read.
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wp_reg] <= wr.data;
    end
  end
endmodule : scw_fifo

/* File: test/scw_properties.sv */
// Concurrent checks on the pins of the control write port.
`timescale 1ns/1ps
module scw_properties (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic [16:0] OUT_ON_O,
  input wire logic [4:0] FB_DIV_O,
  input wire logic SPREAD_ENABLE_O,
  input wire logic BYPASS_O,
  input wire logic Q12_FREQ_SEL_O,
  input wire logic REVISION_O,
  input wire logic [11:0] OUT_HIZ_O
);
  logic [25:0] cfg;
  assign cfg = {OUT_ON_O, FB_DIV_O, SPREAD_ENABLE_O, BYPASS_O,
                Q12_FREQ_SEL_O, REVISION_O};
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_ack_hold;
    SDA_OE_O [*7];
  endsequence
  a_ack_start: assert property (
    $rose(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("ack drive began while clock high");
  a_ack_width: assert property (
    $rose(SDA_OE_O) |-> s_ack_hold)
    else $error("ack pulse too short");
  a_ack_release: assert property (
    SDA_OE_O && $fell(SCL_I) |-> ##[1:6] !SDA_OE_O)
    else $error("ack not released after ninth clock");
  a_sda_value: assert property (
    SDA_O == 1'h0)
    else $error("data pin value not low");
  a_rev_fixed: assert property (
    REVISION_O == 1'h1)
    else $error("revision bit changed");
  a_hiz_held: assert property (
    !$past(RST_B_I) |-> OUT_HIZ_O == 12'hFFF)
    else $error("outputs not floating in reset");
  a_hiz_release: assert property (
    $past(RST_B_I) |-> OUT_HIZ_O == 12'h000)
    else $error("outputs still floating");
  a_commit_idle: assert property (
    !$stable(cfg) |-> $past(SCL_I && SDA_I) && $past(SCL_I && SDA_I, 3))
    else $error("control changed while bus busy");
endmodule : scw_properties

/* File: test/scw_master.sv */
// Behavioural two-wire bus master writing control bytes.
`timescale 1ns/1ps
module scw_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Twice the minimum level time, so the port's synchronisers keep margin.
  localparam int HALF = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic pause();
    repeat (HALF) @(posedge clk_i);
    #1;
  endtask : pause
  task automatic pulse();
    pause();
    scl_o = 1'b1;
    pause();
  endtask : pulse
  // Data moves two cycles after the fall, never in the same step as it.
  task automatic fall();
    scl_o = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : fall
  task automatic start();
    sda_o = 1'b1;
    pulse();
    sda_o = 1'b0;
    pause();
    fall();
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    pulse();
    sda_o = 1'b1;
    pause();
  endtask : stop
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      pulse();
      fall();
    end
    sda_o = 1'b1;
    pulse();
    ack = !sda_i;
    fall();
  endtask : wr_byte
endmodule : scw_master

/* File: test/tb_synth_i2c_control_write_port.sv */
// Self-checking bench for the control write port.
`timescale 1ns/1ps
module tb_synth_i2c_control_write_port;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic addr_sel = 1'b0;
  logic scl, sda_m, sda_o, sda_oe, sda_line;
  logic [16:0] out_on;
  logic [4:0] fb_div;
  logic spread, bypass, freq, rev;
  logic [11:0] hiz;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // The data line has a pull-up, so a released line reads high.
  assign sda_line = sda_m & (sda_oe ? sda_o : 1'b1);
  initial begin
    forever #25 clk = ~clk;
  end
  scw_master i_master(.clk_i(clk), .sda_i(sda_line), .scl_o(scl),
                      .sda_o(sda_m));
  scw_top i_dut(.CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl),
    .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .ADDR_SEL_I(addr_sel), .OUT_ON_O(out_on), .FB_DIV_O(fb_div),
    .SPREAD_ENABLE_O(spread), .BYPASS_O(bypass),
    .Q12_FREQ_SEL_O(freq), .REVISION_O(rev), .OUT_HIZ_O(hiz));
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic check_cfg(input logic [31:0] w);
    cmp(32'(out_on), 32'(w[31:15]), "enables");
    cmp(32'(fb_div), 32'(w[14:10]), "divider");
    cmp({30'h0, spread, bypass}, 32'(w[9:8]), "spread");
    cmp({30'h0, freq, rev}, {30'h0, w[7], 1'h1}, "byte3");
  endtask : check_cfg
  task automatic xfer(input logic [7:0] a, input logic [31:0] d,
                      input int n, output logic [4:0] acks);
    logic ak;
    acks = 5'h0;
    i_master.start();
    i_master.wr_byte(a, ak);
    acks[4] = ak;
    for (int i = 0; i < n; i++) begin
      i_master.wr_byte(d[31-8*i -: 8], ak);
      acks[3-i] = ak;
    end
  endtask : xfer
  task automatic stop_wait();
    i_master.stop();
    repeat (12) @(posedge clk);
    #1;
  endtask : stop_wait
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp(32'(hiz), 32'hFFF, "float");
    check_cfg(32'hF7FFA040);
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    cmp(32'(hiz), 32'h0, "float");
  endtask : t_reset
  task automatic t_write(input logic sel, input logic [31:0] old,
                         input logic [31:0] w);
    logic [4:0] acks;
    addr_sel = sel;
    repeat (4) @(posedge clk);
    #1;
    xfer({5'h13, sel, 2'h0}, w, 4, acks);
    cmp(32'(acks), 32'h1F, "acks");
    repeat (12) @(posedge clk);
    #1;
    check_cfg(old);
    stop_wait();
    check_cfg(w);
  endtask : t_write
  task automatic t_refuse(input logic [31:0] w);
    logic [4:0] acks;
    logic [7:0] bad [2] = '{8'h9C, 8'h99};
    for (int i = 0; i < 2; i++) begin
      xfer(bad[i], ~w, 4, acks);
      stop_wait();
      cmp(32'(acks), 32'h0, "refused acks");
      check_cfg(w);
    end
  endtask : t_refuse
  task automatic t_short(input logic [31:0] w);
    logic [4:0] acks;
    logic ak;
    xfer(8'h98, ~w, 3, acks);
    stop_wait();
    cmp(32'(acks), 32'h1E, "short acks");
    check_cfg(w);
    xfer(8'h98, ~w, 4, acks);
    i_master.wr_byte(8'h00, ak);
    stop_wait();
    cmp(32'(acks), 32'h1F, "long acks");
    cmp(32'(ak), 32'h1, "fifth ack");
    check_cfg(w);
    xfer(8'h98, ~w, 4, acks);
    xfer(8'h9C, ~w, 0, acks);
    stop_wait();
    cmp(32'(acks), 32'h0, "restart acks");
    check_cfg(w);
  endtask : t_short
  // About eight transfers of under a thousand cycles each fit well inside.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    t_reset();
    t_write(1'b0, 32'hF7FFA040, 32'h35CAD6FF);
    t_refuse(32'h35CAD6FF);
    t_short(32'h35CAD6FF);
    t_write(1'b1, 32'h35CAD6FF, 32'hCA35293C);
    t_reset();
    close_out();
  end
endmodule : tb_synth_i2c_control_write_port
bind scw_top scw_properties i_props(.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .OUT_ON_O(OUT_ON_O), .FB_DIV_O(FB_DIV_O),
  .SPREAD_ENABLE_O(SPREAD_ENABLE_O), .BYPASS_O(BYPASS_O),
  .Q12_FREQ_SEL_O(Q12_FREQ_SEL_O), .REVISION_O(REVISION_O),
  .OUT_HIZ_O(OUT_HIZ_O));
